// [hdl/tsvc_pkg.sv]
// package: constants, register map and carriers of the scramble view control
`default_nettype none
package tsvc_pkg;
  // component slots and field widths
  localparam int          NCOMP        = 4;
  localparam int          PID_W        = 13;
  localparam int          KEY_W        = 64;
  localparam int          ADDR_W       = 8;
  // register byte offsets
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_ECM_PID  = 8'h04;
  localparam logic [7:0]  OFF_COMP0    = 8'h08;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_INT_STAT = 8'h1c;
  localparam logic [7:0]  OFF_INT_MASK = 8'h20;
  // control register bits
  localparam int          CTRL_EN      = 0;
  localparam int          CTRL_CARD_OK = 1;
  localparam int          CTRL_CA_DESC = 2;
  localparam int          CTRL_LINK    = 3;
  localparam int          CTRL_W       = 4;
  // component register: pid in low bits, enable and sub-program flag
  localparam int          COMP_EN      = 16;
  localparam int          COMP_SUB     = 17;
  // interrupt bits
  localparam int          IRQ_CARD_BAD = 0;
  localparam int          IRQ_LINK     = 1;
  localparam int          IRQ_COPY     = 2;
  localparam int          IRQ_CAT      = 3;
  localparam int          IRQ_ECM      = 4;
  localparam int          IRQ_W        = 5;
  // status register field positions
  localparam int          ST_CAT       = 0;
  localparam int          ST_VIEW      = 3;
  localparam int          ST_COPY      = 4;
  localparam int          ST_ARMED     = 5;
  localparam int          ST_CARD_BAD  = 6;
  localparam int          ST_LINK      = 7;
  localparam int          ST_RSP       = 8;
  localparam int          ST_SCR       = 16;
  // scrambling control and adaptation field codes
  localparam logic [1:0]  SCR_CLEAR    = 2'h0;
  localparam logic [1:0]  SCR_UNDEF    = 2'h1;
  localparam logic [1:0]  SCR_EVEN     = 2'h2;
  localparam logic [1:0]  SCR_ODD      = 2'h3;
  localparam logic [1:0]  AFC_NONE     = 2'h0;
  localparam logic [1:0]  AFC_ADAPT    = 2'h2;

  // viewing category, one-hot
  typedef enum logic [2:0] {
    CAT_FREE     = 3'b001,
    CAT_CONTRACT = 3'b010,
    CAT_PPV      = 3'b100
  } tsvc_cat_e;

  // card reply kind to an ecm
  typedef enum logic [1:0] {
    RSP_CONTRACT = 2'h0,
    RSP_PPV      = 2'h1,
    RSP_NO_CONTR = 2'h2,
    RSP_ERROR    = 2'h3
  } tsvc_rsp_e;

  // transport packet header as seen by the block
  typedef struct packed {
    logic             valid;
    logic [PID_W-1:0] pid;
    logic [1:0]       scr;
    logic [1:0]       afc;
  } tsvc_hdr_s;

  // card answer to an ecm reception exchange
  typedef struct packed {
    logic             valid;
    tsvc_rsp_e        kind;
    logic             tier_or_ppv;
    logic             tier_held;
    logic             no_record;
    logic [KEY_W-1:0] key_even;
    logic [KEY_W-1:0] key_odd;
  } tsvc_rsp_s;

  // per packet decision
  typedef struct packed {
    logic             valid;
    logic             descramble;
    logic             key_odd;
    logic             sub;
    logic [1:0]       slot;
  } tsvc_dec_s;
endpackage : tsvc_pkg
`default_nettype wire

// [hdl/tsvc_top.sv]
// module: scramble flag classification and viewing control
`default_nettype none
module tsvc_top (
  // clock and reset
  input  wire logic                           MCLK,
  input  wire logic                           RST_B,
  // avalon-mm register slave
  input  wire logic [tsvc_pkg::ADDR_W-1:0]    AVS_ADDRESS,
  input  wire logic                           AVS_READ,
  input  wire logic                           AVS_WRITE,
  input  wire logic [31:0]                    AVS_WRITEDATA,
  input  wire logic [3:0]                     AVS_BYTEENABLE,
  output logic      [31:0]                    AVS_READDATA,
  output logic                                AVS_WAITREQUEST,
  // transport packet headers from the demultiplexer
  input  wire tsvc_pkg::tsvc_hdr_s            TS_HDR,
  // ecm forwarding and card reply
  output logic                                ECM_FWD,
  input  wire tsvc_pkg::tsvc_rsp_s            CARD_RSP,
  // descrambler control
  output tsvc_pkg::tsvc_dec_s                 PKT_DEC,
  output logic      [tsvc_pkg::KEY_W-1:0]     KEY_EVEN,
  output logic      [tsvc_pkg::KEY_W-1:0]     KEY_ODD,
  output logic                                DESC_ARMED,
  // viewing state
  output tsvc_pkg::tsvc_cat_e                 VIEW_CAT,
  output logic                                VIEWABLE,
  output logic                                COPY_GUARD,
  output logic                                CARD_INVALID,
  output logic                                LINK_OP,
  output logic                                IRQ
);

  // whole module state
  typedef struct packed {
    logic                                    waitreq;
    logic [31:0]                             rdata;
    logic [tsvc_pkg::CTRL_W-1:0]             ctrl;
    logic [tsvc_pkg::PID_W-1:0]              ecm_pid;
    logic [tsvc_pkg::NCOMP-1:0][17:0]        comp;
    logic [tsvc_pkg::NCOMP-1:0][1:0]         scr;
    tsvc_pkg::tsvc_cat_e                     cat;
    logic                                    viewable;
    logic                                    copy;
    logic                                    armed;
    logic                                    card_bad;
    logic                                    link;
    logic                                    have_rsp;
    tsvc_pkg::tsvc_rsp_e                     rsp_kind;
    logic                                    tier_or_ppv;
    logic                                    tier_held;
    logic [tsvc_pkg::KEY_W-1:0]              key_even;
    logic [tsvc_pkg::KEY_W-1:0]              key_odd;
    logic [tsvc_pkg::IRQ_W-1:0]              int_stat;
    logic [tsvc_pkg::IRQ_W-1:0]              int_mask;
    logic                                    ecm_fwd;
    tsvc_pkg::tsvc_dec_s                     dec;
    logic                                    irq;
  } tsvc_state_s;

  tsvc_state_s state_q;
  tsvc_state_s state_d;

  // effective scramble state of a packet header
  function automatic logic [1:0] scr_decode(
    input logic [1:0] scr,
    input logic [1:0] afc
  );
    logic [1:0] r;
    r = scr;
    if ((afc == tsvc_pkg::AFC_NONE) || (afc == tsvc_pkg::AFC_ADAPT))
    begin
      r = tsvc_pkg::SCR_UNDEF;
    end
    return r;
  endfunction : scr_decode

  // byte-lane merge for writes
  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // read mux, unmapped offsets read as zero
  function automatic logic [31:0] reg_read(
    input tsvc_state_s          s,
    input logic [7:0]           a
  );
    logic [31:0] r;
    r = 32'h0;
    if (a == tsvc_pkg::OFF_CTRL)
    begin
      r[tsvc_pkg::CTRL_W-1:0] = s.ctrl;
    end
    else if (a == tsvc_pkg::OFF_ECM_PID)
    begin
      r[tsvc_pkg::PID_W-1:0] = s.ecm_pid;
    end
    else if (a == tsvc_pkg::OFF_STATUS)
    begin
      r[tsvc_pkg::ST_CAT +: 3]   = s.cat;
      r[tsvc_pkg::ST_VIEW]       = s.viewable;
      r[tsvc_pkg::ST_COPY]       = s.copy;
      r[tsvc_pkg::ST_ARMED]      = s.armed;
      r[tsvc_pkg::ST_CARD_BAD]   = s.card_bad;
      r[tsvc_pkg::ST_LINK]       = s.link;
      r[tsvc_pkg::ST_RSP +: 2]   = s.rsp_kind;
      r[tsvc_pkg::ST_RSP + 2]    = s.have_rsp;
      r[tsvc_pkg::ST_SCR +: 8]   = s.scr;
    end
    else if (a == tsvc_pkg::OFF_INT_STAT)
    begin
      r[tsvc_pkg::IRQ_W-1:0] = s.int_stat;
    end
    else if (a == tsvc_pkg::OFF_INT_MASK)
    begin
      r[tsvc_pkg::IRQ_W-1:0] = s.int_mask;
    end
    else
    begin
      for (int i = 0; i < tsvc_pkg::NCOMP; i++)
      begin
        if (a == tsvc_pkg::OFF_COMP0 + 8'(4 * i))
        begin
          r[17:0] = s.comp[i];
        end
      end
    end
    return r;
  endfunction : reg_read

  // next state
  always_comb
  begin
    logic [31:0]                 wv;
    logic [1:0]                  ps;
    logic                        all_clear;
    logic                        any_sel;
    logic                        to_ppv;
    logic [tsvc_pkg::IRQ_W-1:0]  ev;
    logic                        bad_now;
    logic                        link_now;
    tsvc_pkg::tsvc_cat_e         ncat;
    wv        = 32'h0;
    ps        = tsvc_pkg::SCR_UNDEF;
    all_clear = 1'b1;
    any_sel   = 1'b0;
    to_ppv    = 1'b0;
    ev        = '0;
    bad_now   = 1'b0;
    link_now  = 1'b0;
    ncat      = tsvc_pkg::CAT_FREE;
    state_d   = state_q;
    state_d.ecm_fwd   = 1'b0;
    state_d.dec.valid = 1'b0;

    // bus slave: one wait cycle, transfer takes effect when waitreq is low
    state_d.waitreq = 1'b1;
    if ((AVS_READ || AVS_WRITE) && state_q.waitreq)
    begin
      state_d.waitreq = 1'b0;
      state_d.rdata   = reg_read(state_q, AVS_ADDRESS);
    end
    if (AVS_WRITE && !state_q.waitreq)
    begin
      wv = be_merge(reg_read(state_q, AVS_ADDRESS), AVS_WRITEDATA,
                    AVS_BYTEENABLE);
      if (AVS_ADDRESS == tsvc_pkg::OFF_CTRL)
      begin
        state_d.ctrl = wv[tsvc_pkg::CTRL_W-1:0];
      end
      else if (AVS_ADDRESS == tsvc_pkg::OFF_ECM_PID)
      begin
        state_d.ecm_pid = wv[tsvc_pkg::PID_W-1:0];
      end
      else if (AVS_ADDRESS == tsvc_pkg::OFF_INT_STAT)
      begin
        state_d.int_stat = state_q.int_stat & ~wv[tsvc_pkg::IRQ_W-1:0];
      end
      else if (AVS_ADDRESS == tsvc_pkg::OFF_INT_MASK)
      begin
        state_d.int_mask = wv[tsvc_pkg::IRQ_W-1:0];
      end
      for (int i = 0; i < tsvc_pkg::NCOMP; i++)
      begin
        if (AVS_ADDRESS == tsvc_pkg::OFF_COMP0 + 8'(4 * i))
        begin
          // new component set forgets its old flag
          state_d.comp[i] = wv[17:0];
          state_d.scr[i]  = tsvc_pkg::SCR_UNDEF;
        end
      end
    end

    // packet classification against the selected components
    ps = scr_decode(TS_HDR.scr, TS_HDR.afc);
    if (TS_HDR.valid && state_q.ctrl[tsvc_pkg::CTRL_EN])
    begin
      for (int i = 0; i < tsvc_pkg::NCOMP; i++)
      begin
        // sub-program slots take exactly the same path
        if (state_q.comp[i][tsvc_pkg::COMP_EN] &&
            (state_q.comp[i][tsvc_pkg::PID_W-1:0] == TS_HDR.pid))
        begin
          if (ps != tsvc_pkg::SCR_UNDEF)
          begin
            state_d.scr[i] = ps;
          end
          state_d.dec.valid      = 1'b1;
          state_d.dec.slot       = 2'(i);
          state_d.dec.sub        = state_q.comp[i][tsvc_pkg::COMP_SUB];
          // clear packets bypass the descrambler
          state_d.dec.descramble = state_q.viewable &&
                                   (ps[1] == 1'b1);
          state_d.dec.key_odd    = (ps == tsvc_pkg::SCR_ODD);
        end
      end
      // ecm packets go to the card only while it is valid
      if ((TS_HDR.pid == state_q.ecm_pid) &&
          state_q.ctrl[tsvc_pkg::CTRL_CARD_OK])
      begin
        state_d.ecm_fwd = 1'b1;
        state_d.armed   = 1'b1;
        ev[tsvc_pkg::IRQ_ECM] = 1'b1;
      end
    end

    // card reply: keys and recording control
    if (CARD_RSP.valid)
    begin
      state_d.have_rsp    = 1'b1;
      state_d.rsp_kind    = CARD_RSP.kind;
      state_d.tier_or_ppv = CARD_RSP.tier_or_ppv;
      state_d.tier_held   = CARD_RSP.tier_held;
      state_d.copy        = CARD_RSP.no_record;
      if (CARD_RSP.kind != tsvc_pkg::RSP_ERROR)
      begin
        state_d.key_even = CARD_RSP.key_even;
        state_d.key_odd  = CARD_RSP.key_odd;
      end
    end
    // disabling the block drops the armed path and reply
    if (!state_d.ctrl[tsvc_pkg::CTRL_EN])
    begin
      state_d.armed    = 1'b0;
      state_d.have_rsp = 1'b0;
      state_d.copy     = 1'b0;
    end

    // category evaluated every cycle from flags and reply
    for (int i = 0; i < tsvc_pkg::NCOMP; i++)
    begin
      if (state_d.comp[i][tsvc_pkg::COMP_EN])
      begin
        any_sel = 1'b1;
        if (state_d.scr[i] != tsvc_pkg::SCR_CLEAR)
        begin
          all_clear = 1'b0;
        end
      end
    end
    to_ppv = (state_d.rsp_kind == tsvc_pkg::RSP_PPV) ||
             (state_d.tier_or_ppv && !state_d.tier_held);
    if (!any_sel || all_clear)
    begin
      ncat = tsvc_pkg::CAT_FREE;
    end
    else if (state_d.have_rsp && to_ppv)
    begin
      ncat = tsvc_pkg::CAT_PPV;
    end
    else
    begin
      ncat = tsvc_pkg::CAT_CONTRACT;
    end
    state_d.cat = ncat;
    case (ncat)
      tsvc_pkg::CAT_FREE:
        state_d.viewable = 1'b1;
      tsvc_pkg::CAT_CONTRACT,
      tsvc_pkg::CAT_PPV:
        state_d.viewable = state_d.have_rsp &&
          ((state_d.rsp_kind == tsvc_pkg::RSP_CONTRACT) ||
           (state_d.rsp_kind == tsvc_pkg::RSP_PPV));
      default:
        state_d.viewable = 1'b0;
    endcase
    // free content carries no copy restriction from the card while the descrambler is not armed
    if (ncat == tsvc_pkg::CAT_FREE && !state_d.armed)
    begin
      state_d.copy = 1'b0;
    end

    // indications
    bad_now  = state_d.ctrl[tsvc_pkg::CTRL_CA_DESC] &&
               !state_d.ctrl[tsvc_pkg::CTRL_CARD_OK];
    link_now = state_d.have_rsp &&
               (state_d.rsp_kind == tsvc_pkg::RSP_NO_CONTR) &&
               state_d.ctrl[tsvc_pkg::CTRL_LINK];
    state_d.card_bad = bad_now;
    state_d.link     = link_now;
    ev[tsvc_pkg::IRQ_CARD_BAD] = bad_now && !state_q.card_bad;
    ev[tsvc_pkg::IRQ_LINK]     = link_now && !state_q.link;
    ev[tsvc_pkg::IRQ_COPY]     = state_d.copy && !state_q.copy;
    ev[tsvc_pkg::IRQ_CAT]      = (ncat != state_q.cat);

    // sticky status: a new event beats a same-cycle clear
    state_d.int_stat = state_d.int_stat | ev;
    state_d.irq      = |(state_d.int_stat & state_d.int_mask);
  end

  // state register
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_q         <= '0;
      state_q.waitreq <= 1'b1;
      state_q.cat     <= tsvc_pkg::CAT_FREE;
      state_q.scr     <= '1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state register
  assign AVS_READDATA    = state_q.rdata;
  assign AVS_WAITREQUEST = state_q.waitreq;
  assign ECM_FWD         = state_q.ecm_fwd;
  assign PKT_DEC         = state_q.dec;
  assign KEY_EVEN        = state_q.key_even;
  assign KEY_ODD         = state_q.key_odd;
  assign DESC_ARMED      = state_q.armed;
  assign VIEW_CAT        = state_q.cat;
  assign VIEWABLE        = state_q.viewable;
  assign COPY_GUARD      = state_q.copy;
  assign CARD_INVALID    = state_q.card_bad;
  assign LINK_OP         = state_q.link;
  assign IRQ             = state_q.irq;

endmodule : tsvc_top
`default_nettype wire

// [tb/tsvc_sva.sv]
// checker: port-level properties of the scramble view control
`default_nettype none
module tsvc_sva (
  // clock and reset
  input wire logic                       MCLK,
  input wire logic                       RST_B,
  // register bus handshake
  input wire logic                       AVS_READ,
  input wire logic                       AVS_WRITE,
  input wire logic                       AVS_WAITREQUEST,
  // stream headers and card reply
  input wire tsvc_pkg::tsvc_hdr_s        TS_HDR,
  input wire tsvc_pkg::tsvc_rsp_s        CARD_RSP,
  // decisions and viewing state
  input wire logic                       ECM_FWD,
  input wire tsvc_pkg::tsvc_dec_s        PKT_DEC,
  input wire logic [tsvc_pkg::KEY_W-1:0] KEY_EVEN,
  input wire logic [tsvc_pkg::KEY_W-1:0] KEY_ODD,
  input wire logic                       DESC_ARMED,
  input wire tsvc_pkg::tsvc_cat_e        VIEW_CAT,
  input wire logic                       COPY_GUARD
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  // bus answers one cycle after taking, low for one cycle only
  bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("bus answer late");
  wait_pulse_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  // decisions only follow a taken header
  pkt_cause_a: assert property (PKT_DEC.valid |-> $past(TS_HDR.valid))
    else $error("decision without header");
  odd_key_a: assert property (PKT_DEC.valid |-> PKT_DEC.key_odd ==
    ($past(TS_HDR.scr) == tsvc_pkg::SCR_ODD && $past(TS_HDR.afc[0])))
    else $error("odd key select wrong");
  clear_bypass_a: assert property (PKT_DEC.valid && PKT_DEC.descramble
    |-> $past(TS_HDR.scr[1]) && $past(TS_HDR.afc[0]))
    else $error("clear or undefined packet descrambled");
  ecm_arm_a: assert property (ECM_FWD |-> ##[0:1] DESC_ARMED)
    else $error("ecm did not arm descrambler");
  ecm_cause_a: assert property (ECM_FWD |-> $past(TS_HDR.valid))
    else $error("ecm forward without header");
  one_cat_a: assert property ($onehot(VIEW_CAT))
    else $error("category not one-hot");
  session_key_a: assert property (CARD_RSP.valid &&
    CARD_RSP.kind == tsvc_pkg::RSP_CONTRACT |=> KEY_EVEN ==
    $past(CARD_RSP.key_even) && KEY_ODD == $past(CARD_RSP.key_odd))
    else $error("session key not taken");
  copy_guard_a: assert property (CARD_RSP.valid && CARD_RSP.no_record &&
    CARD_RSP.kind == tsvc_pkg::RSP_CONTRACT |=> COPY_GUARD)
    else $error("copy guard missing");
endmodule : tsvc_sva

bind tsvc_top tsvc_sva i_sva (.MCLK(MCLK), .RST_B(RST_B),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .TS_HDR(TS_HDR), .CARD_RSP(CARD_RSP),
  .ECM_FWD(ECM_FWD), .PKT_DEC(PKT_DEC), .KEY_EVEN(KEY_EVEN),
  .KEY_ODD(KEY_ODD), .DESC_ARMED(DESC_ARMED), .VIEW_CAT(VIEW_CAT),
  .COPY_GUARD(COPY_GUARD));
`default_nettype wire

// [tb/tsvc_card_model.sv]
// model: conditional access card answering forwarded ecms
`default_nettype none
module tsvc_card_model (
  // clock and reset
  input  wire logic                MCLK,
  input  wire logic                RST_B,
  // reply content and latency set by the bench
  input  wire tsvc_pkg::tsvc_rsp_s SETUP,
  input  wire logic [3:0]          DELAY,
  // ecm request and reply
  input  wire logic                ECM_FWD,
  output tsvc_pkg::tsvc_rsp_s      CARD_RSP
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt_q;

  // reply DELAY+1 cycles after a forward; idle keys churn so a stale
  // sample one cycle late can never pass for the real reply
  always_ff @(posedge MCLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt_q    <= 5'h00;
      CARD_RSP <= '0;
    end
    else
    begin
      if (!ECM_FWD && cnt_q == 5'h01)
      begin
        // whole reply in one assignment, valid raised together with it
        cnt_q    <= 5'h00;
        CARD_RSP <= '{1'b1, SETUP.kind, SETUP.tier_or_ppv, SETUP.tier_held,
                      SETUP.no_record, SETUP.key_even, SETUP.key_odd};
      end
      else
      begin
        CARD_RSP.valid    <= 1'b0;
        CARD_RSP.key_even <= ~CARD_RSP.key_even;
        CARD_RSP.key_odd  <= ~CARD_RSP.key_odd;
        if (ECM_FWD)
          cnt_q <= {1'b0, DELAY} + 5'h01;
        else if (cnt_q != 5'h00)
          cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule : tsvc_card_model
`default_nettype wire

// [tb/tsvc_top_bench.sv]
// bench: scenarios for the scramble view control
`default_nettype none
module tsvc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] KEY_E = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] KEY_O = 64'hfedc_ba98_7654_3210;
  localparam logic [12:0] ECM   = 13'h100;
  logic                mclk, rst_b, rd, wr, waitreq, ecm_fwd, armed;
  logic                viewable, copy_guard, card_bad, link_op, irq;
  logic [7:0]          adr;
  logic [31:0]         wdata, rdata;
  logic [63:0]         key_even, key_odd;
  logic [3:0]          delay;
  tsvc_pkg::tsvc_hdr_s hdr;
  tsvc_pkg::tsvc_rsp_s rsp, cfg;
  tsvc_pkg::tsvc_dec_s dec;
  tsvc_pkg::tsvc_cat_e cat;
  int                  errors, num_checks;

  tsvc_top i_dut (.MCLK(mclk), .RST_B(rst_b), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .TS_HDR(hdr), .ECM_FWD(ecm_fwd), .CARD_RSP(rsp), .PKT_DEC(dec),
    .KEY_EVEN(key_even), .KEY_ODD(key_odd), .DESC_ARMED(armed),
    .VIEW_CAT(cat), .VIEWABLE(viewable), .COPY_GUARD(copy_guard),
    .CARD_INVALID(card_bad), .LINK_OP(link_op), .IRQ(irq));
  tsvc_card_model i_card (.MCLK(mclk), .RST_B(rst_b), .SETUP(cfg),
    .DELAY(delay), .ECM_FWD(ecm_fwd), .CARD_RSP(rsp));

  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // one access; held until waitrequest is seen low at an edge
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d,
                     output logic [31:0] q);
    int n = 0;
    @(posedge mclk);
    adr   <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    do
    begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 50)
    begin
      errors++;
      test_done();
    end
  endtask : bus

  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge mclk);
    #1;
  endtask : wr_reg

  // header taken at the second edge, decision read just after it
  task automatic send(logic [12:0] pid, logic [1:0] scr, logic [1:0] afc);
    @(posedge mclk);
    hdr <= '{1'b1, pid, scr, afc};
    @(posedge mclk);
    hdr.valid <= 1'b0;
    #1;
  endtask : send

  // ecm header, then wait for the card and the edge that takes its reply
  task automatic ecm_round(tsvc_pkg::tsvc_rsp_e k, logic t, logic h,
                           logic n, logic [3:0] d);
    int i = 0;
    @(posedge mclk);
    // an error reply carries an odd key that must never be taken
    cfg   <= '{1'b0, k, t, h, n, KEY_E,
              (k == tsvc_pkg::RSP_ERROR) ? ~KEY_O : KEY_O};
    delay <= d;
    send(ECM, tsvc_pkg::SCR_CLEAR, 2'h1);
    check("ecm forwarded", ecm_fwd, 1'b1);
    while (rsp.valid !== 1'b1 && i < 50)
    begin
      @(posedge mclk);
      #1;
      i++;
    end
    if (i >= 50)
    begin
      errors++;
      test_done();
    end
    @(posedge mclk);
    #1;
  endtask : ecm_round

  task automatic t_regs();
    logic [31:0] q;
    bus(1'b0, tsvc_pkg::OFF_STATUS, 32'h0, q);
    check("status cat", q[3:0], 4'h9);
    check("status flags", q[23:16], 8'hff);
    bus(1'b0, 8'h40, 32'h0, q);
    check("unmapped read", q, 32'h0);
    wr_reg(tsvc_pkg::OFF_ECM_PID, 32'hffff_ffff);
    bus(1'b0, tsvc_pkg::OFF_ECM_PID, 32'h0, q);
    check("ecm pid", q, 32'h1fff);
    wr_reg(tsvc_pkg::OFF_ECM_PID, {19'h0, ECM});
    wr_reg(tsvc_pkg::OFF_COMP0, 32'h0001_0020);
    wr_reg(tsvc_pkg::OFF_COMP0 + 8'h04, 32'h0003_0021);
    wr_reg(tsvc_pkg::OFF_CTRL, 32'h3);
    $display("test regs done");
  endtask : t_regs

  task automatic t_flags();
    logic [31:0] q;
    // {scr, afc, expected slot flag}; undefined codes keep the old flag
    logic [5:0]  tbl [7] = '{6'b000100, 6'b101110, 6'b010110, 6'b110111,
                             6'b110011, 6'b001011, 6'b001100};
    foreach (tbl[i])
    begin
      send(13'h20, tbl[i][5:4], tbl[i][3:2]);
      check("decision", dec.valid, 1'b1);
      check("odd key", dec.key_odd, tbl[i][5:4] == 2'h3 && tbl[i][2]);
      bus(1'b0, tsvc_pkg::OFF_STATUS, 32'h0, q);
      check("slot flag", q[17:16], tbl[i][1:0]);
    end
    send(13'h21, tsvc_pkg::SCR_CLEAR, 2'h1);
    check("sub slot", {dec.valid, dec.sub, dec.slot}, 4'hd);
    check("free", cat, tsvc_pkg::CAT_FREE);
    check("free viewable", viewable, 1'b1);
    send(13'h55, tsvc_pkg::SCR_ODD, 2'h1);
    check("foreign pid", dec.valid, 1'b0);
    $display("test flags done");
  endtask : t_flags

  task automatic t_contract();
    ecm_round(tsvc_pkg::RSP_CONTRACT, 1'b0, 1'b0, 1'b1, 4'h3);
    check("armed while clear", armed, 1'b1);
    check("clear stays free", cat, tsvc_pkg::CAT_FREE);
    check("even key", key_even, KEY_E);
    check("odd key", key_odd, KEY_O);
    send(13'h20, tsvc_pkg::SCR_EVEN, 2'h1);
    check("contract", cat, tsvc_pkg::CAT_CONTRACT);
    check("viewable", viewable, 1'b1);
    check("copy guard", copy_guard, 1'b1);
    send(13'h20, tsvc_pkg::SCR_EVEN, 2'h3);
    check("descramble", dec.descramble, 1'b1);
    send(13'h21, tsvc_pkg::SCR_CLEAR, 2'h1);
    check("clear bypass", dec.descramble, 1'b0);
    $display("test contract done");
  endtask : t_contract

  task automatic t_ppv();
    for (int i = 0; i < 3; i++)
    begin
      ecm_round(i == 0 ? tsvc_pkg::RSP_PPV : tsvc_pkg::RSP_CONTRACT,
                i != 0, i == 2, 1'b0, 4'h0);
      check("category", cat, i == 2 ? tsvc_pkg::CAT_CONTRACT
                                    : tsvc_pkg::CAT_PPV);
      check("viewable", viewable, 1'b1);
      check("copy off", copy_guard, 1'b0);
    end
    $display("test ppv done");
  endtask : t_ppv

  task automatic t_link();
    wr_reg(tsvc_pkg::OFF_CTRL, 32'hb);
    ecm_round(tsvc_pkg::RSP_NO_CONTR, 1'b0, 1'b0, 1'b0, 4'h1);
    check("link op", link_op, 1'b1);
    check("not viewable", viewable, 1'b0);
    ecm_round(tsvc_pkg::RSP_ERROR, 1'b0, 1'b0, 1'b0, 4'h2);
    check("error keeps key", key_odd, KEY_O);
    check("link off", link_op, 1'b0);
    check("error not viewable", viewable, 1'b0);
    wr_reg(tsvc_pkg::OFF_CTRL, 32'h0);
    check("disarmed", armed, 1'b0);
    $display("test link done");
  endtask : t_link

  task automatic t_card();
    logic [31:0] q;
    wr_reg(tsvc_pkg::OFF_INT_STAT, 32'h1f);
    wr_reg(tsvc_pkg::OFF_INT_MASK, 32'h1);
    check("irq idle", irq, 1'b0);
    wr_reg(tsvc_pkg::OFF_CTRL, 32'h5);
    check("card invalid", card_bad, 1'b1);
    check("irq raised", irq, 1'b1);
    send(ECM, tsvc_pkg::SCR_CLEAR, 2'h1);
    check("no forward", ecm_fwd, 1'b0);
    bus(1'b0, tsvc_pkg::OFF_INT_STAT, 32'h0, q);
    check("status bit", q[0], 1'b1);
    wr_reg(tsvc_pkg::OFF_INT_STAT, 32'h1);
    check("irq cleared", irq, 1'b0);
    $display("test card done");
  endtask : t_card

  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    rst_b      = 1'b0;
    rd         = 1'b0;
    wr         = 1'b0;
    adr        = 8'h00;
    wdata      = 32'h0;
    hdr        = '0;
    cfg        = '0;
    delay      = 4'h0;
    errors     = 0;
    num_checks = 0;
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    t_regs();
    t_flags();
    t_contract();
    t_ppv();
    t_link();
    t_card();
    test_done();
  end
endmodule : tsvc_top_bench
`default_nettype wire
